// *** pkg/kwd_pkg.sv ***
// ------------------------------------------------------------
// keyed watchdog constants
// ------------------------------------------------------------
package kwd_pkg;

  // apb register byte offsets
  localparam logic [7:0] KWD_ADDR_WDC    = 8'h00;  // watchdog_control
  localparam logic [7:0] KWD_ADDR_MISC   = 8'h04;  // misc_control
  localparam logic [7:0] KWD_ADDR_STAT   = 8'h08;  // timeout status, mode
  localparam logic [7:0] KWD_ADDR_IRQST  = 8'h0C;  // sticky events, write 1 clears
  localparam logic [7:0] KWD_ADDR_IRQMSK = 8'h10;  // event mask
  localparam logic [7:0] KWD_ADDR_COUNT  = 8'h14;  // live counter value

  // watchdog_control layout and reset value
  localparam logic [7:0] KWD_WDC_RESET = 8'h53;
  localparam int         KWD_KEY_MSB   = 7;
  localparam int         KWD_KEY_LSB   = 3;
  localparam int         KWD_SEL_MSB   = 2;
  localparam logic [4:0] KWD_KEY_A     = 5'h0A;
  localparam logic [4:0] KWD_KEY_B     = 5'h15;

  // misc_control bits
  localparam int KWD_MISC_SOFT = 0;  // soft_reset_flag
  localparam int KWD_MISC_USER = 1;  // free user bit

  // event bits
  localparam int KWD_EV_TIMEOUT = 0;
  localparam int KWD_EV_KEYRST  = 1;

  // counter and debounce
  localparam int         KWD_CNT_W        = 18;
  localparam logic [4:0] KWD_CNT_W_U5     = 5'd18;
  localparam logic [1:0] KWD_DEB_LAST     = 2'd2;  // third internal osc edge fires

  // power modes, one-hot
  typedef enum logic [2:0] {
    KWD_RUN   = 3'b001,
    KWD_SLEEP = 3'b010,
    KWD_IDLE  = 3'b100
  } kwd_mode_t;

  // period exponent for each timeout_select_field code
  function automatic logic [4:0] kwd_period_exp(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'd18;
    case (sel)
      3'h0:    e = 5'd8;
      3'h1:    e = 5'd10;
      3'h2:    e = 5'd12;
      3'h3:    e = 5'd14;
      3'h4:    e = 5'd15;
      3'h5:    e = 5'd16;
      3'h6:    e = 5'd17;
      default: e = 5'd18;
    endcase
    return e;
  endfunction : kwd_period_exp

endpackage : kwd_pkg

// *** verilog/kwd_edge_tick.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// slow clock level to one-cycle enable pulse
// ------------------------------------------------------------
module kwd_edge_tick (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_lvl,
  output logic      tick
);

  logic prev_r;
  logic prev_nxt;
  logic tick_r;
  logic tick_nxt;

  // rising edge of the slow level becomes one pclk pulse
  always_comb begin
    prev_nxt = clk_lvl;
    tick_nxt = clk_lvl & ~prev_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : kwd_edge_tick

// *** verilog/kwd_watchdog.sv ***
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - counter advances on sub clock edges, internal osc or crystal per option
// - timeout period is sub clock divided by power of two, 2^8..2^18
// - select codes 000,001,010,111 give 2^8,2^10,2^12,2^18
// - control register loads 0x53 on any reset except timeout warm reset
// - watchdog enabled when key field is 01010 or 10101
// - illegal key gives full reset after 2 to 3 internal osc cycles
// - illegal key reset sets the soft reset flag
// - overflow while running resets device and sets timeout flag
// - overflow in idle sets timeout flag, clears only pc and sp
// - counter cleared by key reset, clear instruction or halt
// - halt into sleep clears counter and stops it
// - halt into idle clears counter, counting continues from zero
// - after reset counter starts at zero and counts at once
module kwd_watchdog
  import kwd_pkg::*;
#(
  parameter int CNT_W = KWD_CNT_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        int_osc_clk_in,
  input  wire logic        xtal_osc_clk_in,
  input  wire logic        cfg_xtal_sel,
  input  wire logic        wd_clear_pulse,
  input  wire logic        halt_pulse,
  input  wire logic        idle_en,
  input  wire logic        wake_pulse,
  output logic             device_reset,
  output logic             pc_sp_clear,
  output logic             irq
);

  // ------------------------------------------------------------
  // slow clock enables
  // ------------------------------------------------------------
  logic sub_lvl;
  logic sub_tick;
  logic osc_tick;

  assign sub_lvl = cfg_xtal_sel ? xtal_osc_clk_in : int_osc_clk_in;

  kwd_edge_tick u_sub_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_lvl (sub_lvl),
    .tick    (sub_tick)
  );

  // debounce always runs off the internal osc, whatever the option
  kwd_edge_tick u_osc_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_lvl (int_osc_clk_in),
    .tick    (osc_tick)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]       wdc_r, wdc_nxt;
  logic             soft_r, soft_nxt;
  logic             user_r, user_nxt;
  logic             to_r, to_nxt;
  logic [1:0]       ev_r, ev_nxt;
  logic [1:0]       msk_r, msk_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0]       deb_r, deb_nxt;
  kwd_mode_t        mode_r, mode_nxt;
  logic             rst_r, rst_nxt;
  logic             pcsp_r, pcsp_nxt;
  logic             irq_r, irq_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic             err_r, err_nxt;
  logic             rdy_r, rdy_nxt;

  logic [4:0]       key;
  logic             key_ok;
  logic             key_fire;
  logic [CNT_W-1:0] limit;
  logic             ovf;
  logic             wr_acc;
  logic             mapped;

  assign key    = wdc_r[KWD_KEY_MSB:KWD_KEY_LSB];
  assign key_ok = (key == KWD_KEY_A) || (key == KWD_KEY_B);

  assign limit = CNT_W'({CNT_W{1'b1}} >> (KWD_CNT_W_U5 - kwd_period_exp(wdc_r[KWD_SEL_MSB:0])));

  // third internal osc edge after the bad key was seen
  assign key_fire = !key_ok && osc_tick && (deb_r == KWD_DEB_LAST);

  // overflow only while enabled and not stopped in sleep
  assign ovf    = sub_tick && key_ok && (mode_r != KWD_SLEEP) && (cnt_r == limit)
                  && !wd_clear_pulse && !halt_pulse;
  assign wr_acc = psel && penable && pwrite && rdy_r;
  assign mapped = (paddr == KWD_ADDR_WDC) || (paddr == KWD_ADDR_MISC) ||
                  (paddr == KWD_ADDR_STAT) || (paddr == KWD_ADDR_IRQST) ||
                  (paddr == KWD_ADDR_IRQMSK) || (paddr == KWD_ADDR_COUNT);

  // ------------------------------------------------------------
  // watchdog core and registers, next values
  // ------------------------------------------------------------
  always_comb begin
    wdc_nxt   = wdc_r;
    soft_nxt  = soft_r;
    user_nxt  = user_r;
    to_nxt    = to_r;
    ev_nxt    = ev_r;
    msk_nxt   = msk_r;
    cnt_nxt   = cnt_r;
    deb_nxt   = deb_r;
    mode_nxt  = mode_r;
    rst_nxt   = 1'b0;
    pcsp_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    rdy_nxt   = 1'b1;  // every access answered at once

    // software writes first, hardware events below override them
    if (wr_acc) begin
      case (paddr)
        KWD_ADDR_WDC: wdc_nxt = pwdata[7:0];
        KWD_ADDR_MISC: begin
          user_nxt = pwdata[KWD_MISC_USER];
          if (!pwdata[KWD_MISC_SOFT]) begin
            soft_nxt = 1'b0;
          end
        end
        KWD_ADDR_IRQST:  ev_nxt  = ev_r & ~pwdata[1:0];
        KWD_ADDR_IRQMSK: msk_nxt = pwdata[1:0];
        default: ;
      endcase
    end

    if (sub_tick && key_ok && (mode_r != KWD_SLEEP)) begin
      cnt_nxt = cnt_r + 1'b1;
    end

    // debounce counter runs only while the key is bad
    if (key_ok) begin
      deb_nxt = '0;
    end else if (osc_tick) begin
      deb_nxt = deb_r + 1'b1;
    end

    if (wd_clear_pulse) begin
      cnt_nxt = '0;
    end

    // power mode sequencing
    case (mode_r)
      KWD_RUN: begin
        if (halt_pulse) begin
          // halt clears counter; sleep also stops it
          cnt_nxt  = '0;
          to_nxt   = 1'b0;
          mode_nxt = idle_en ? KWD_IDLE : KWD_SLEEP;
        end else if (ovf) begin
          // warm device reset, control register kept
          rst_nxt = 1'b1;
          to_nxt  = 1'b1;
          cnt_nxt = '0;
          ev_nxt[KWD_EV_TIMEOUT] = 1'b1;
        end
      end
      KWD_SLEEP, KWD_IDLE: begin
        if (ovf) begin
          // restart via pc and sp only
          pcsp_nxt = 1'b1;
          to_nxt   = 1'b1;
          cnt_nxt  = '0;
          mode_nxt = KWD_RUN;
          ev_nxt[KWD_EV_TIMEOUT] = 1'b1;
        end else if (wake_pulse) begin
          mode_nxt = KWD_RUN;
        end
      end
      default: mode_nxt = KWD_RUN;
    endcase

    // a bad key holds the counter clear
    if (!key_ok) begin
      cnt_nxt = '0;
    end

    // full reset from bad key: beats every other update
    if (key_fire) begin
      // control register back to its reset value
      wdc_nxt  = KWD_WDC_RESET;
      soft_nxt = 1'b1;
      to_nxt   = 1'b0;
      rst_nxt  = 1'b1;
      cnt_nxt  = '0;
      deb_nxt  = '0;
      mode_nxt = KWD_RUN;
      ev_nxt[KWD_EV_KEYRST] = 1'b1;
    end

    // read data captured in setup phase, zero wait state
    if (psel && !penable) begin
      err_nxt   = !mapped;
      rdata_nxt = '0;
      case (paddr)
        KWD_ADDR_WDC:    rdata_nxt[7:0] = wdc_r;
        KWD_ADDR_MISC:   rdata_nxt[1:0] = {user_r, soft_r};
        KWD_ADDR_STAT:   rdata_nxt[3:0] = {mode_r, to_r};
        KWD_ADDR_IRQST:  rdata_nxt[1:0] = ev_r;
        KWD_ADDR_IRQMSK: rdata_nxt[1:0] = msk_r;
        KWD_ADDR_COUNT:  rdata_nxt[CNT_W-1:0] = cnt_r;
        default: ;
      endcase
    end

    irq_nxt = |(ev_nxt & msk_nxt);
  end

  // registers; an unmapped write is dropped by the decode above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdc_r   <= KWD_WDC_RESET;
      soft_r  <= 1'b0;
      user_r  <= 1'b0;
      to_r    <= 1'b0;
      ev_r    <= '0;
      msk_r   <= '0;
      cnt_r   <= '0;
      deb_r   <= '0;
      mode_r  <= KWD_RUN;
      rst_r   <= 1'b0;
      pcsp_r  <= 1'b0;
      irq_r   <= 1'b0;
      rdata_r <= '0;
      err_r   <= 1'b0;
      rdy_r   <= 1'b0;
    end else begin
      wdc_r   <= wdc_nxt;
      soft_r  <= soft_nxt;
      user_r  <= user_nxt;
      to_r    <= to_nxt;
      ev_r    <= ev_nxt;
      msk_r   <= msk_nxt;
      cnt_r   <= cnt_nxt;
      deb_r   <= deb_nxt;
      mode_r  <= mode_nxt;
      rst_r   <= rst_nxt;
      pcsp_r  <= pcsp_nxt;
      irq_r   <= irq_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  assign prdata       = rdata_r;
  assign pready       = rdy_r;  // low in reset, then high: zero wait
  assign pslverr      = err_r;
  assign device_reset = rst_r;
  assign pc_sp_clear  = pcsp_r;
  assign irq          = irq_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_key_reload;
    key_fire |=> (wdc_r == KWD_WDC_RESET) && device_reset;
  endproperty
  a_key_reload: assert property (p_key_reload) else $error("key reset did not reload");
  property p_soft_flag;
    key_fire |=> soft_r [*2];
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("soft flag not set");
  property p_debounce;
    key_fire |-> !key_ok && !$past(key_ok, 2) && (deb_r == KWD_DEB_LAST);
  endproperty
  a_debounce: assert property (p_debounce) else $error("key reset too early");
  property p_run_ovf;
    (ovf && mode_r == KWD_RUN && !key_fire) |=> device_reset && to_r && !pc_sp_clear
                                                && (cnt_r == '0);
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("run overflow wrong");

  property p_idle_ovf;
    (ovf && mode_r == KWD_IDLE && !key_fire) |=> pc_sp_clear && to_r && !device_reset
                                                 && (mode_r == KWD_RUN);
  endproperty
  a_idle_ovf: assert property (p_idle_ovf) else $error("idle overflow wrong");

  property p_sleep_stopped;
    (mode_r == KWD_SLEEP) |-> (cnt_r == '0);
  endproperty
  a_sleep_stopped: assert property (p_sleep_stopped) else $error("counter ran in sleep");

  property p_halt_idle;
    (halt_pulse && idle_en && mode_r == KWD_RUN && !key_fire) |=>
      (cnt_r == '0) && (mode_r == KWD_IDLE);
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("halt to idle wrong");
  property p_clear;
    wd_clear_pulse |=> (cnt_r == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear not honoured");
  property p_count;
    (sub_tick && key_ok && mode_r != KWD_SLEEP && !wd_clear_pulse && !halt_pulse
     && !key_fire && cnt_r != limit) |=> (cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");

  property p_period;
    (sub_tick && key_ok && cnt_r == limit && mode_r != KWD_SLEEP) |->
      (cnt_r[KWD_SEL_MSB:0] == 3'h7) && ((wdc_r[KWD_SEL_MSB:0] != 3'h0) || (cnt_r == 18'h000FF));
  endproperty
  a_period: assert property (p_period) else $error("period terminal count wrong");

  c_run_ovf:  cover property (ovf && mode_r == KWD_RUN);
  c_idle_ovf: cover property (ovf && mode_r == KWD_IDLE);
  c_key_rst:  cover property (key_fire);
  c_sleep:    cover property (mode_r == KWD_SLEEP ##1 wake_pulse);

endmodule : kwd_watchdog

// *** verif/kwd_core_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// processor core: clear, halt and wake requests
// ------------------------------------------------------------
module kwd_core_model (
  input  wire logic pclk,
  output logic      wd_clear_pulse,
  output logic      halt_pulse,
  output logic      idle_en,
  output logic      wake_pulse
);
  // quiet core until the bench asks for an instruction
  initial begin
    wd_clear_pulse = 1'b0;
    halt_pulse    = 1'b0;
    idle_en       = 1'b0;
    wake_pulse    = 1'b0;
  end

  task automatic clear();
    @(posedge pclk);
    wd_clear_pulse <= 1'b1;
    @(posedge pclk);
    wd_clear_pulse <= 1'b0;
  endtask : clear

  // idle_en qualifies the halt in the same cycle
  task automatic halt(input logic idle);
    @(posedge pclk);
    halt_pulse <= 1'b1;
    idle_en    <= idle;
    @(posedge pclk);
    halt_pulse <= 1'b0;
  endtask : halt

  task automatic wake();
    @(posedge pclk);
    wake_pulse <= 1'b1;
    @(posedge pclk);
    wake_pulse <= 1'b0;
  endtask : wake
endmodule : kwd_core_model

// *** verif/keyed_watchdog_timer_tb.sv ***
`timescale 1ns/1ps
module keyed_watchdog_timer_tb;
  import kwd_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        int_osc = 1'b0, xtal_osc = 1'b0, xtal_sel = 1'b0, slv_err;
  logic        pready, pslverr, device_reset, pc_sp_clear, irq;
  logic        wd_clear_pulse, halt_pulse, idle_en, wake_pulse;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int          fail_count = 0, samples_checked = 0, rst_seen = 0, n, base, osc_div = 0;

  always #20 pclk = ~pclk;

  // slow oscillators: internal every 2 cycles, crystal every 6; reset pulse count
  always @(posedge pclk) begin
    int_osc <= ~int_osc;
    osc_div <= (osc_div == 2) ? 0 : osc_div + 1;
    if (osc_div == 2) xtal_osc <= ~xtal_osc;
    if (device_reset === 1'b1) rst_seen <= rst_seen + 1;
  end

  kwd_watchdog i_kwd_watchdog (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_osc_clk_in(int_osc), .xtal_osc_clk_in(xtal_osc), .cfg_xtal_sel(xtal_sel),
    .wd_clear_pulse(wd_clear_pulse), .halt_pulse(halt_pulse), .idle_en(idle_en),
    .wake_pulse(wake_pulse), .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
    .irq(irq)
  );

  kwd_core_model i_kwd_core_model (
    .pclk(pclk), .wd_clear_pulse(wd_clear_pulse), .halt_pulse(halt_pulse),
    .idle_en(idle_en), .wake_pulse(wake_pulse)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic in_range(input int got, input int lo, input int hi);
    chk((got >= lo && got <= hi) ? 32'(lo) : 32'(got), 32'(lo));
  endtask : in_range

  // apb transfer: setup, then access held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: a stuck slave is left to the hang guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // cycles until reset pulse (or pc/sp clear pulse), bounded
  task automatic wait_ev(input logic on_pcsp);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((on_pcsp ? pc_sp_clear : device_reset) !== 1'b1 && n < 40000);
  endtask : wait_ev

  task automatic t_reset();
    rd(KWD_ADDR_WDC, 32'h53);
    apb(1'b0, KWD_ADDR_COUNT, 32'h0);
    chk(32'(q < 32'h20), 32'h1);
    n = int'(q);
    repeat (20) @(posedge pclk);
    apb(1'b0, KWD_ADDR_COUNT, 32'h0);
    chk(32'(q > 32'(n)), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, slv_err}, 32'h1);
  endtask : t_reset

  task automatic t_key();
    wr(KWD_ADDR_WDC, 32'h07);
    wait_ev(1'b0);
    in_range(n, 3, 14);
    rd(KWD_ADDR_WDC, 32'h53);
    rd(KWD_ADDR_MISC, 32'h1);
  endtask : t_key

  // timeout periods: codes 0..3 on internal osc, code 0 on crystal
  task automatic t_timeouts();
    int per, tgt;
    for (int s = 0; s < 5; s++) begin
      per = (s == 4) ? 6 : 2;
      tgt = per * (1 << ((s == 4) ? 8 : 8 + 2 * s));
      xtal_sel <= (s == 4);
      wr(KWD_ADDR_WDC, {24'h0, (s % 2 == 1) ? KWD_KEY_B : KWD_KEY_A, 3'((s == 4) ? 0 : s)});
      i_kwd_core_model.clear();
      wait_ev(1'b0);
      in_range(n, tgt - per - 8, tgt + per + 8);
      rd(KWD_ADDR_STAT, 32'h3);
      rd(KWD_ADDR_WDC, {24'h0, (s % 2 == 1) ? KWD_KEY_B : KWD_KEY_A, 3'((s == 4) ? 0 : s)});
    end
    rd(KWD_ADDR_MISC, 32'h1);
    wr(KWD_ADDR_MISC, 32'h2);
    rd(KWD_ADDR_MISC, 32'h2);
  endtask : t_timeouts

  task automatic t_clr();
    xtal_sel <= 1'b0;
    wr(KWD_ADDR_WDC, {24'h0, KWD_KEY_B, 3'h0});
    i_kwd_core_model.clear();
    base = rst_seen;
    repeat (4) begin
      repeat (400) @(posedge pclk);
      i_kwd_core_model.clear();
    end
    chk(32'(rst_seen - base), 32'h0);
  endtask : t_clr

  task automatic t_sleep_idle();
    i_kwd_core_model.halt(1'b0);
    base = rst_seen;
    repeat (1200) @(posedge pclk);
    rd(KWD_ADDR_COUNT, 32'h0);
    rd(KWD_ADDR_STAT, 32'h4);
    chk(32'(rst_seen - base), 32'h0);
    i_kwd_core_model.wake();
    i_kwd_core_model.halt(1'b1);
    base = rst_seen;
    wait_ev(1'b1);
    in_range(n, 502, 522);
    chk(32'(rst_seen - base), 32'h0);
    apb(1'b0, KWD_ADDR_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    i_kwd_core_model.wake();
  endtask : t_sleep_idle

  // events: raise, mask, clear
  task automatic t_irq();
    wr(KWD_ADDR_WDC, 32'h57);
    wr(KWD_ADDR_IRQMSK, 32'h0);
    wr(KWD_ADDR_IRQST, 32'h3);
    rd(KWD_ADDR_IRQST, 32'h0);
    wr(KWD_ADDR_IRQMSK, 32'h2);
    wr(KWD_ADDR_WDC, 32'h07);
    repeat (20) @(posedge pclk);
    rd(KWD_ADDR_IRQST, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(KWD_ADDR_IRQMSK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(KWD_ADDR_IRQMSK, 32'h2);
    wr(KWD_ADDR_IRQST, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // hang guard, 80k cycles against about 50k expected
  initial begin
    #3_200_000;
    fail_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_key();
    t_timeouts();
    t_clr();
    t_sleep_idle();
    t_irq();
    results();
  end
endmodule : keyed_watchdog_timer_tb
